/* File: rtl/rsp_pkg.sv */
// rsp_pkg: constants shared by the serial slave port and its master
// assumes: nothing beyond plain SystemVerilog
package rsp_pkg;
    localparam int RSP_MEM_DEPTH = 128;
    localparam logic [6:0] RSP_IDX_CTRL = 7'h0F;
    localparam logic [6:0] RSP_IDX_STATUS = 7'h10;
    localparam logic [6:0] RSP_IDX_TCC = 7'h11;
    localparam logic [7:0] RSP_TCC_RESET = 8'h5C;
    localparam logic [7:0] RSP_CTRL_MASK = 8'h47;
    localparam logic [7:0] RSP_WP_MASK = 8'h40;
    localparam int RSP_WP_BIT = 6;
    localparam int RSP_DIR_BIT = 7;
    localparam logic [6:0] RSP_CLK_LAST = 7'h1F;
    localparam logic [6:0] RSP_CLK_FIRST = 7'h00;
    localparam logic [6:0] RSP_RAM_LAST = 7'h7F;
    localparam logic [6:0] RSP_RAM_FIRST = 7'h20;
    localparam logic [3:0] RSP_KEY_ON = 4'hA;
    localparam int RSP_KEY_LSB = 4;
    localparam int RSP_DS_LSB = 2;
    localparam int RSP_RS_LSB = 0;
    localparam logic [1:0] RSP_DS_ONE = 2'h1;
    localparam logic [1:0] RSP_DS_TWO = 2'h2;
    localparam logic [1:0] RSP_RS_OFF = 2'h0;
    // master register map (APB byte addresses)
    localparam logic [7:0] RSP_OFS_CMD = 8'h00;
    localparam logic [7:0] RSP_OFS_RX = 8'h04;
    localparam logic [7:0] RSP_OFS_STAT = 8'h08;
    localparam logic [7:0] RSP_OFS_CFG = 8'h0C;
    localparam int RSP_CMD_LAST_BIT = 8;
    localparam int RSP_CFG_3W_BIT = 0;
    localparam int RSP_CFG_CPOL_BIT = 1;
    localparam int RSP_CFG_HALF_LSB = 8;
    localparam logic [7:0] RSP_HALF_RESET = 8'h08;
    localparam logic [3:0] RSP_PH_LAST = 4'hF;
    typedef enum logic [2:0] {
        RSP_IDLE = 3'b000,
        RSP_SETUP = 3'b001,
        RSP_SHIFT = 3'b011,
        RSP_WAIT = 3'b010,
        RSP_END = 3'b110
    } rsp_state_t;
endpackage

/* File: rtl/rsp_link_if.sv */
// rsp_link_if: serial link between master and slave port
// assumes: io is pulled high when nobody drives it
`timescale 1ns/1ps
interface rsp_link_if;
    logic ce;
    logic sclk;
    logic host_dout;
    logic host_oe;
    logic dev_dout;
    logic dev_oe;
    logic io_level;
    logic sdo_level;
    // shared data line of the three-wire mode
    assign io_level = host_oe ? host_dout : (dev_oe ? dev_dout : 1'b1);
    assign sdo_level = dev_oe ? dev_dout : 1'b1;
    modport dev (
        input ce,
        input sclk,
        input host_dout,
        input io_level,
        output dev_dout,
        output dev_oe
    );
    modport host (
        output ce,
        output sclk,
        output host_dout,
        output host_oe,
        input sdo_level,
        input io_level
    );
endinterface

/* File: rtl/rsp_sync.sv */
// rsp_sync: two-flop synchroniser for levels from outside pclk
// assumes: each bit is an independent level
`timescale 1ns/1ps
module rsp_sync #(
    parameter int W = 1
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* File: rtl/rsp_dev.sv */
// rsp_dev: serial slave port with clock/RAM store and charge control
// assumes: link pins and supply flags are asynchronous to pclk
//
// Implementation choice: the serial slave port.
`timescale 1ns/1ps
module rsp_dev
    import rsp_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    rsp_link_if.dev link, // serial link
    input wire logic interface_select_strap, // high four-wire, low three-wire
    input wire logic on_battery, // running from backup battery
    output logic charge_enable, // trickle charger on
    output logic [1:0] diode_count_sel, // diode field of charger
    output logic [1:0] resistor_sel, // resistor field of charger
    output logic write_lock // write-lock control bit
);
    ////////////////////////////////////////////////////////////////
    // input synchronisation and edge detection
    logic [5:0] raw;
    logic [5:0] syn;
    logic ce_s;
    logic sclk_s;
    logic sdi_s;
    logic io_s;
    logic four_wire;
    logic batt_s;
    logic ce_prev_q;
    logic sclk_prev_q;
    logic pol_q;

    assign raw = {link.ce, link.sclk, link.host_dout, link.io_level,
                  interface_select_strap, on_battery};

    rsp_sync #(
        .W(6)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw),
        .q(syn)
    );

    assign ce_s = syn[5];
    assign sclk_s = syn[4];
    assign sdi_s = syn[3];
    assign io_s = syn[2];
    assign four_wire = syn[1];
    assign batt_s = syn[0];

    wire ce_rise = ce_s & ~ce_prev_q;
    wire active = ce_s & ce_prev_q;
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    // four-wire: input on the edge back to idle, output on the edge away
    wire strobe = four_wire ? (pol_q ? sclk_rise : sclk_fall) : sclk_rise;
    wire shift = four_wire ? (pol_q ? sclk_fall : sclk_rise) : sclk_fall;
    wire strobe_ev = active & strobe;
    wire shift_ev = active & shift;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ce_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            pol_q <= 1'b0;
        end
        else
        begin
            ce_prev_q <= ce_s;
            sclk_prev_q <= sclk_s;
            if (ce_rise)
                pol_q <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // byte assembly and address decode
    logic [7:0] sh_q;
    logic [2:0] bitcnt_q;
    logic have_addr_q;
    logic wr_q;
    logic [6:0] ptr_q;
    logic [7:0] out_q;
    logic dout_q;
    logic oe_q;
    logic [7:0] mem_q [RSP_MEM_DEPTH];

    wire din = four_wire ? sdi_s : io_s;
    wire [7:0] byte_in = four_wire ? {sh_q[6:0], din} : {din, sh_q[7:1]};
    wire byte_done = strobe_ev & (bitcnt_q == 3'h7);
    wire is_addr = byte_done & ~have_addr_q;
    wire is_data = byte_done & have_addr_q;
    wire [6:0] addr_in = byte_in[6:0];
    wire dir_in = byte_in[RSP_DIR_BIT];
    wire lock = mem_q[RSP_IDX_CTRL][RSP_WP_BIT];

    // pointer advance with separate wrap ranges
    wire [6:0] ptr_inc = ptr_q + 7'h01;
    wire [6:0] ptr_nxt = (ptr_q == RSP_CLK_LAST) ? RSP_CLK_FIRST :
                         (ptr_q == RSP_RAM_LAST) ? RSP_RAM_FIRST : ptr_inc;

    // write gating: battery, lock, read-only status
    wire to_ctrl = (ptr_q == RSP_IDX_CTRL);
    wire wr_ok = ~batt_s & (~lock | to_ctrl) & (ptr_q != RSP_IDX_STATUS);
    wire mem_we = is_data & wr_q & wr_ok;
    wire [7:0] ctrl_locked = (mem_q[RSP_IDX_CTRL] & ~RSP_WP_MASK) | (byte_in & RSP_WP_MASK);
    wire [7:0] ctrl_open = byte_in & RSP_CTRL_MASK;
    wire [7:0] ctrl_wdata = lock ? ctrl_locked : ctrl_open;
    wire [7:0] wdata = to_ctrl ? ctrl_wdata : byte_in;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q <= 8'h00;
            bitcnt_q <= 3'h0;
            have_addr_q <= 1'b0;
            wr_q <= 1'b0;
            ptr_q <= 7'h00;
            out_q <= 8'h00;
        end
        else if (!ce_s)
        begin
            bitcnt_q <= 3'h0;
            have_addr_q <= 1'b0;
        end
        else
        begin
            if (strobe_ev)
            begin
                sh_q <= byte_in;
                bitcnt_q <= bitcnt_q + 3'h1;
            end
            if (is_addr)
            begin
                have_addr_q <= 1'b1;
                wr_q <= dir_in;
                ptr_q <= addr_in;
                out_q <= mem_q[addr_in];
            end
            else if (is_data)
            begin
                ptr_q <= ptr_nxt;
                out_q <= mem_q[ptr_nxt];
            end
            else if (shift_ev & have_addr_q & ~wr_q)
                out_q <= four_wire ? {out_q[6:0], 1'b0} : {1'b0, out_q[7:1]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // storage: clock registers, control, status, charger, user RAM
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < RSP_MEM_DEPTH; i++)
                mem_q[i] <= (i == int'(RSP_IDX_TCC)) ? RSP_TCC_RESET : 8'h00;
        end
        else if (mem_we)
            mem_q[ptr_q] <= wdata;
    end

    ////////////////////////////////////////////////////////////////
    // serial output: driven only during the data phase of a read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (!ce_s)
            oe_q <= 1'b0;
        else if (shift_ev & have_addr_q & ~wr_q)
        begin
            dout_q <= four_wire ? out_q[7] : out_q[0];
            oe_q <= 1'b1;
        end
    end

    assign link.dev_dout = dout_q;
    assign link.dev_oe = oe_q;

    ////////////////////////////////////////////////////////////////
    // trickle charger decode
    wire [7:0] tcc = mem_q[RSP_IDX_TCC];
    wire [3:0] key = tcc[RSP_KEY_LSB +: 4];
    wire [1:0] ds = tcc[RSP_DS_LSB +: 2];
    wire [1:0] rs = tcc[RSP_RS_LSB +: 2];
    wire key_ok = (key == RSP_KEY_ON);
    wire ds_ok = (ds == RSP_DS_ONE) | (ds == RSP_DS_TWO);
    wire rs_ok = (rs != RSP_RS_OFF);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            charge_enable <= 1'b0;
            diode_count_sel <= 2'h0;
            resistor_sel <= 2'h0;
            write_lock <= 1'b0;
        end
        else
        begin
            charge_enable <= key_ok & ds_ok & rs_ok;
            diode_count_sel <= ds;
            resistor_sel <= rs;
            write_lock <= lock;
        end
    end
endmodule

/* File: rtl/rsp_host.sv */
// rsp_host: serial master driven by software over APB
// assumes: one slave on the link; software sends the address byte first
`timescale 1ns/1ps
module rsp_host
    import rsp_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    rsp_link_if.host link // serial link
);
    ////////////////////////////////////////////////////////////////
    // registers and APB decode
    rsp_state_t st_q;
    logic [15:0] cfg_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic last_q;
    logic first_q;
    logic dir_q;
    logic rdph_q;
    logic [7:0] cnt_q;
    logic [3:0] ph_q;
    logic ce_q;
    logic sclk_q;
    logic dout_q;
    logic oe_q;
    logic [1:0] syn;

    rsp_sync #(
        .W(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.sdo_level, link.io_level}),
        .q(syn)
    );

    wire three = cfg_q[RSP_CFG_3W_BIT];
    wire cpol = cfg_q[RSP_CFG_CPOL_BIT];
    wire [7:0] half = cfg_q[RSP_CFG_HALF_LSB +: 8];
    wire busy = (st_q != RSP_IDLE) & (st_q != RSP_WAIT);
    wire setup = psel & ~penable;
    wire hit_cmd = (paddr == RSP_OFS_CMD);
    wire hit_rx = (paddr == RSP_OFS_RX);
    wire hit_stat = (paddr == RSP_OFS_STAT);
    wire hit_cfg = (paddr == RSP_OFS_CFG);
    wire hit = hit_cmd | hit_rx | hit_stat | hit_cfg;
    wire wr = psel & penable & pready & pwrite;
    wire go = wr & hit_cmd & ~busy;
    wire [31:0] rd_mux = hit_rx ? {24'h0, rx_q} :
                         hit_stat ? {30'h0, ce_q, busy} :
                         hit_cfg ? {16'h0, cfg_q} : 32'h0;
    wire tick = (cnt_q == half - 8'h01) | (half == 8'h00);
    wire rd_in = three ? syn[0] : syn[1];
    wire [7:0] tx_sh = three ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            cfg_q <= {RSP_HALF_RESET, 8'h00};
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= setup ? rd_mux : 32'h0;
            if (wr & hit_cfg & ~busy)
                cfg_q <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // link sequencer: one command byte per start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= RSP_IDLE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            last_q <= 1'b0;
            first_q <= 1'b0;
            dir_q <= 1'b0;
            rdph_q <= 1'b0;
            cnt_q <= 8'h00;
            ph_q <= 4'h0;
            ce_q <= 1'b0;
            sclk_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            cnt_q <= (busy & ~tick) ? cnt_q + 8'h01 : 8'h00;
            if (go)
            begin
                tx_q <= pwdata[7:0];
                last_q <= pwdata[RSP_CMD_LAST_BIT];
            end
            case (st_q)
                RSP_IDLE:
                begin
                    // three-wire always idles low so that rising edges take data in and falling edges move it
                    sclk_q <= cpol & ~three;
                    if (go)
                    begin
                        ce_q <= 1'b1;
                        oe_q <= 1'b1;
                        first_q <= 1'b1;
                        dir_q <= pwdata[RSP_DIR_BIT];
                        st_q <= RSP_SETUP;
                    end
                end
                RSP_SETUP:
                    if (tick)
                    begin
                        dout_q <= three ? tx_q[0] : tx_q[7];
                        ph_q <= 4'h0;
                        st_q <= RSP_SHIFT;
                    end
                RSP_SHIFT:
                    if (tick)
                    begin
                        sclk_q <= ~sclk_q;
                        ph_q <= ph_q + 4'h1;
                        if (!ph_q[0] & three)
                            rx_q <= {rd_in, rx_q[7:1]};
                        if (ph_q[0] & ~three)
                            rx_q <= {rx_q[6:0], rd_in};
                        // data never moves with the strobe edge: it passes the same
                        // synchroniser as the clock in the slave and would be taken early
                        if ((ph_q[0] == three) & (ph_q != 4'h0))
                        begin
                            tx_q <= tx_sh;
                            dout_q <= three ? tx_sh[0] : tx_sh[7];
                        end
                        if (ph_q == RSP_PH_LAST)
                        begin
                            first_q <= 1'b0;
                            if (first_q & ~dir_q)
                                rdph_q <= 1'b1;
                            if (first_q & ~dir_q & three)
                                oe_q <= 1'b0;
                            st_q <= last_q ? RSP_END : RSP_WAIT;
                        end
                    end
                RSP_WAIT:
                    if (go)
                        st_q <= RSP_SETUP;
                RSP_END:
                    if (tick)
                    begin
                        ph_q <= ph_q + 4'h1;
                        ce_q <= 1'b0;
                        oe_q <= 1'b0;
                        rdph_q <= 1'b0;
                        if (ph_q[0])
                            st_q <= RSP_IDLE;
                    end
                default:
                    st_q <= RSP_IDLE;
            endcase
        end
    end

    assign link.ce = ce_q;
    assign link.sclk = sclk_q;
    assign link.host_dout = dout_q;
    assign link.host_oe = oe_q;
endmodule

/* File: dv/rsp_chk_sva.sv */
// rsp_chk: wire-level checks on the link between master and slave port, plus the charger output fields
// assumes: instantiated in the bench beside the link interface, strap static per frame
`timescale 1ns/1ps
module rsp_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic ce, // select
    input wire logic sclk, // shift clock
    input wire logic host_dout, // master data
    input wire logic host_oe, // master drives io
    input wire logic dev_dout, // slave data
    input wire logic dev_oe, // slave drives
    input wire logic interface_select_strap, // mode strap
    input wire logic charge_enable, // charger on
    input wire logic [1:0] diode_count_sel, // diode field
    input wire logic [1:0] resistor_sel // resistor field
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    logic pol_q;
    logic sclk_q;
    logic [7:0] edge_q;
    // idle polarity is the clock level while deselected; edges counted per frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pol_q <= 1'b0;
            sclk_q <= 1'b0;
            edge_q <= 8'h00;
        end
        else
        begin
            sclk_q <= sclk;
            pol_q <= ce ? pol_q : sclk;
            edge_q <= !ce ? 8'h00 : edge_q + {7'h00, sclk != sclk_q};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_OE_RELEASE: assert property ((!ce)[*6] |-> !dev_oe)
        else $error("slave still drives after deselect");
    AST_NO_FIGHT: assert property (!interface_select_strap && host_oe |-> !dev_oe)
        else $error("both ends drive the shared line");
    AST_BYTES: assert property ($fell(ce) |-> edge_q[3:0] == 4'h0 && edge_q != 8'h00)
        else $error("frame is not whole bytes");
    AST_DRIVE_AFTER_ADDR: assert property ($rose(dev_oe) |-> ce && edge_q >= 8'h10)
        else $error("slave drives before address byte done");
    AST_CHG_FIELDS: assert property (charge_enable |-> resistor_sel != 2'b00 &&
        (diode_count_sel == 2'b01 || diode_count_sel == 2'b10))
        else $error("charger on with disabling field");
    AST_3W_DEV_EDGE: assert property (!interface_select_strap && dev_oe && $changed(dev_dout)
        |-> !sclk)
        else $error("three-wire slave data moved while clock high");
    AST_3W_HOST_EDGE: assert property (!interface_select_strap && ce && host_oe &&
        $changed(host_dout) |-> !sclk)
        else $error("three-wire master data moved while clock high");
    AST_4W_DEV_EDGE: assert property (interface_select_strap && ce && dev_oe &&
        $changed(dev_dout) |-> sclk != pol_q)
        else $error("four-wire slave data moved off the shift edge");
    AST_4W_HOST_EDGE: assert property (interface_select_strap && ce && $changed(host_dout)
        |-> !$changed(sclk) || sclk != pol_q)
        else $error("four-wire master data moved on the strobe edge");
endmodule

/* File: dv/rtc_serial_slave_port_test.sv */
// rtc_serial_slave_port_test: APB-driven master against the slave port, model compared
// assumes: package, interface, master and slave from rtl/
`timescale 1ns/1ps
module rtc_serial_slave_port_test;
    import rsp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic strap = 1'b1;
    logic on_batt = 1'b0;
    logic charge_enable;
    logic write_lock;
    logic [1:0] dsel;
    logic [1:0] rsel;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] lfsr_q = 32'h9FC99714;
    logic [7:0] mem [128];
    logic [7:0] wq [$];
    logic [7:0] ptr;
    logic [7:0] exp_addr = 8'h00;
    logic [31:0] r;
    logic err;
    logic [7:0] tv [12] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hA4, 8'hA1, 8'hAD,
        8'hB5, 8'h25, 8'h5C};
    rsp_link_if rsp_link_if_i ();
    rsp_dev rsp_dev_i (.pclk(pclk), .presetn(presetn), .link(rsp_link_if_i),
        .interface_select_strap(strap), .on_battery(on_batt), .charge_enable(charge_enable),
        .diode_count_sel(dsel), .resistor_sel(rsel), .write_lock(write_lock));
    rsp_host rsp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(rsp_link_if_i));
    rsp_chk rsp_chk_i (.pclk(pclk), .presetn(presetn), .ce(rsp_link_if_i.ce),
        .sclk(rsp_link_if_i.sclk), .host_dout(rsp_link_if_i.host_dout),
        .host_oe(rsp_link_if_i.host_oe), .dev_dout(rsp_link_if_i.dev_dout),
        .dev_oe(rsp_link_if_i.dev_oe), .interface_select_strap(strap),
        .charge_enable(charge_enable), .diode_count_sel(dsel), .resistor_sel(rsel));
    always #4 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [7:0] rnd();
        lfsr_q = lfsr_q[0] ? (lfsr_q >> 1) ^ 32'h80200003 : lfsr_q >> 1;
        return lfsr_q[7:0];
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 40 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 40)
        begin
            bad_count++;
            $display("BAD apb ready expected 1 seen 0");
            close_out();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 400; k++)
        begin
            apb(1'b0, RSP_OFS_STAT, 32'h00000000);
            if (r[0] === 1'b0)
                break;
        end
        if (k == 400)
        begin
            bad_count++;
            $display("BAD busy expected 0 seen 1");
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // behavioural slave: write filtering and pointer wrap
    function automatic void m_wr(input logic [7:0] a, input logic [7:0] v);
        logic [6:0] i;
        i = a[6:0];
        if (on_batt || i == 7'h10 || (mem[7'h0F][6] && i != 7'h0F))
            return;
        if (i == 7'h0F)
            mem[i] = mem[i][6] ? ((mem[i] & 8'hBF) | (v & 8'h40)) : (v & 8'h47);
        else
            mem[i] = v;
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] a);
        if (a[6:0] == 7'h1F)
            return {a[7], 7'h00};
        if (a[6:0] == 7'h7F)
            return {a[7], 7'h20};
        return a + 8'h01;
    endfunction
    task automatic xfer(input logic [7:0] a, input int n);
        logic [7:0] v;
        ptr = a;
        exp_addr = a;
        wait_idle();
        apb(1'b1, RSP_OFS_CMD, {24'h000000, a});
        for (int i = 0; i < n; i++)
        begin
            v = (wq.size() > 0) ? wq.pop_front() : (a[7] ? rnd() : 8'h00);
            wait_idle();
            apb(1'b1, RSP_OFS_CMD, {23'h000000, i == n - 1, v});
            if (a[7])
                m_wr(ptr, v);
            else
            begin
                wait_idle();
                apb(1'b0, RSP_OFS_RX, 32'h00000000);
                chk("read byte", ptr[6:0] == 7'h10 ? 8'h00 : mem[ptr[6:0]], r[7:0]);
            end
            ptr = nxt(ptr);
        end
        wait_idle();
    endtask
    task automatic chk_chg();
        logic [7:0] t;
        t = mem[7'h11];
        chk("charge enable", {7'h00, t[7:4] == 4'hA && (t[3:2] == 2'b01 || t[3:2] == 2'b10)
            && t[1:0] != 2'b00}, {7'h00, charge_enable});
        chk("diode select", {6'h00, t[3:2]}, {6'h00, dsel});
        chk("resistor select", {6'h00, t[1:0]}, {6'h00, rsel});
        chk("write lock", {7'h00, mem[7'h0F][6]}, {7'h00, write_lock});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // address byte as seen on the wire at the strobe edges
    logic mon_sclk_q = 1'b0;
    logic mon_pol = 1'b0;
    logic mon_d = 1'b0;
    logic [7:0] mon_sh = 8'h00;
    int mon_n = 0;
    always @(posedge pclk)
    begin
        mon_sclk_q <= rsp_link_if_i.sclk;
        mon_d <= strap ? rsp_link_if_i.host_dout : rsp_link_if_i.io_level;
        if (!rsp_link_if_i.ce)
        begin
            mon_n <= 0;
            mon_pol <= strap ? rsp_link_if_i.sclk : 1'b1;
        end
        else if (mon_n < 8 && rsp_link_if_i.sclk != mon_sclk_q && rsp_link_if_i.sclk == mon_pol)
        begin
            mon_sh <= strap ? {mon_sh[6:0], mon_d} : {mon_d, mon_sh[7:1]};
            mon_n <= mon_n + 1;
        end
        else if (mon_n == 8)
        begin
            chk("address on wire", exp_addr, mon_sh);
            mon_n <= 9;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        mem[7'h11] = 8'h5C;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            strap <= (m != 2);
            apb(1'b1, RSP_OFS_CFG, {16'h0000, RSP_HALF_RESET, 6'h00, m == 1, m == 2});
            repeat (4) @(posedge pclk);
            chk_chg();
            xfer(8'h11, 1);
            tv[11] = rnd();
            for (int i = 0; i < 12; i++)
            begin
                wq.push_back(tv[i]);
                xfer(8'h91, 1);
                xfer(8'h11, 1);
                chk_chg();
            end
            xfer(8'hFE, 4);
            xfer(8'h7E, 4);
            xfer(8'h9E, 3);
            xfer(8'h1F, 2);
            wq = '{8'h07, 8'hFF};
            xfer(8'h8F, 2);
            xfer(8'h0F, 3);
            wq = '{8'hC0};
            xfer(8'h8F, 1);
            chk_chg();
            xfer(8'hA0, 2);
            wq = '{8'h03};
            xfer(8'h8F, 1);
            chk_chg();
            xfer(8'h0F, 1);
            xfer(8'h20, 2);
            on_batt <= 1'b1;
            repeat (4) @(posedge pclk);
            xfer(8'hA0, 2);
            xfer(8'h91, 1);
            chk_chg();
            on_batt <= 1'b0;
            repeat (4) @(posedge pclk);
            xfer(8'h20, 2);
        end
        apb(1'b0, 8'h10, 32'h00000000);
        chk("unmapped error", 8'h01, {7'h00, err});
        chk("unmapped data", 8'h00, r[7:0]);
        close_out();
    end
endmodule
